// *** logic/ssf_status_regs.sv ***
// per-sample status flags, status alias and auto-increment read port
`timescale 1ns/1ps
module ssf_status_regs (
    input  wire logic                core_clk_i,    // 100 MHz system clock
    input  wire logic                resetn_i,      // async reset, active low
    input  wire logic [1:0]          fifo_mode_i,   // fifo setup mode field
    input  wire ssf_pkg::ssf_evcfg_t event_cfg_i,   // event flag enables
    input  wire ssf_pkg::ssf_sample_t sample_i,     // finished acquisitions
    input  wire logic [7:0]          fifo_status_i, // fifo status byte
    input  wire logic [7:0]          fifo_data_i,   // fifo head byte
    input  wire logic                ptr_load_i,    // load register pointer
    input  wire logic [7:0]          ptr_addr_i,    // pointer value to load
    input  wire logic                byte_sent_i,   // byte at pointer shipped
    output logic [7:0]               rd_data_o,     // byte at current pointer
    output logic [7:0]               ptr_o,         // current pointer
    output logic [7:0]               sample_status_o // live status register
);
    logic [ssf_pkg::NUM_FLAGS-1:0] flag_set;
    logic [ssf_pkg::NUM_FLAGS-1:0] flag_clr;
    logic [ssf_pkg::NUM_FLAGS-1:0] flag_q;
    logic [7:0]  status_byte;
    logic [7:0]  ptr_d;
    logic [7:0]  ptr_q;
    logic [7:0]  rd_data_d;
    logic [7:0]  rd_data_q;
    logic [7:0]  stat_out_q;
    logic [19:0] p_val_d;
    logic [19:0] p_val_q;
    logic [11:0] t_val_d;
    logic [11:0] t_val_q;
    logic        fifo_on;
    logic        clr_p;
    logic        clr_t;
    logic        p_ow_ev;
    logic        t_ow_ev;

    // flag slots of the flag vector
    localparam ssf_pkg::ssf_flag_idx_t F_ANY_OW  = ssf_pkg::F_ANY_OW;
    localparam ssf_pkg::ssf_flag_idx_t F_P_OW    = ssf_pkg::F_P_OW;
    localparam ssf_pkg::ssf_flag_idx_t F_T_OW    = ssf_pkg::F_T_OW;
    localparam ssf_pkg::ssf_flag_idx_t F_ANY_RDY = ssf_pkg::F_ANY_RDY;
    localparam ssf_pkg::ssf_flag_idx_t F_P_RDY   = ssf_pkg::F_P_RDY;
    localparam ssf_pkg::ssf_flag_idx_t F_T_RDY   = ssf_pkg::F_T_RDY;

    // any nonzero mode (circular, stop-full or code 3) routes reads to the fifo
    assign fifo_on = (fifo_mode_i != ssf_pkg::FMODE_OFF);

    // next pointer of the auto-increment walk
    function automatic logic [7:0] next_addr(input logic [7:0] a, input logic fon);
        logic [7:0] n;
        n = a + 8'h01;
        if (a == ssf_pkg::ADDR_WRAP_LAST) begin
            n = ssf_pkg::ADDR_STATUS_ALIAS;
        end else if (fon && a == ssf_pkg::ADDR_FIFO_DATA_A) begin
            n = ssf_pkg::ADDR_FIFO_DATA_A;
        end
        return n;
    endfunction

    function automatic logic [7:0] read_byte(input logic [7:0] a, input logic fon,
                                             input logic [7:0] st, input logic [19:0] p,
                                             input logic [11:0] t, input logic [7:0] fst,
                                             input logic [7:0] fdat);
        logic [7:0] v;
        v = ssf_pkg::UNMAPPED_VALUE;
        case (a)
            ssf_pkg::ADDR_STATUS_ALIAS: v = fon ? fst : st;
            ssf_pkg::ADDR_P_MSB:        v = fon ? fdat : p[19:12];
            ssf_pkg::ADDR_P_CSB:        v = fon ? ssf_pkg::UNMAPPED_VALUE : p[11:4];
            ssf_pkg::ADDR_P_LSB:        v = fon ? ssf_pkg::UNMAPPED_VALUE : {p[3:0], 4'h0};
            ssf_pkg::ADDR_T_MSB:        v = fon ? ssf_pkg::UNMAPPED_VALUE : t[11:4];
            ssf_pkg::ADDR_T_LSB:        v = fon ? ssf_pkg::UNMAPPED_VALUE : {t[3:0], 4'h0};
            ssf_pkg::ADDR_SAMPLE_STAT:  v = st;
            ssf_pkg::ADDR_FIFO_STAT:    v = fst;
            ssf_pkg::ADDR_FIFO_DATA:    v = fdat;
            default:                    v = ssf_pkg::UNMAPPED_VALUE;
        endcase
        return v;
    endfunction

    // reserved bits 4 and 0 are tied low
    always_comb begin
        status_byte = ssf_pkg::SAMPLE_STAT_RST;
        status_byte[ssf_pkg::BIT_ANY_OW]  = flag_q[F_ANY_OW];
        status_byte[ssf_pkg::BIT_P_OW]    = flag_q[F_P_OW];
        status_byte[ssf_pkg::BIT_T_OW]    = flag_q[F_T_OW];
        status_byte[ssf_pkg::BIT_ANY_RDY] = flag_q[F_ANY_RDY];
        status_byte[ssf_pkg::BIT_P_RDY]   = flag_q[F_P_RDY];
        status_byte[ssf_pkg::BIT_T_RDY]   = flag_q[F_T_RDY];
    end

    // set events: an overwrite is a new sample landing on an unread one
    always_comb begin
        p_ow_ev  = sample_i.p_done && flag_q[F_P_RDY];
        t_ow_ev  = sample_i.t_done && flag_q[F_T_RDY];
        flag_set = '0;
        flag_set[F_P_RDY]   = sample_i.p_done && event_cfg_i.pressure_event_enable;
        flag_set[F_P_OW]    = p_ow_ev && event_cfg_i.pressure_event_enable;
        flag_set[F_T_RDY]   = sample_i.t_done && event_cfg_i.temperature_event_enable;
        flag_set[F_T_OW]    = t_ow_ev && event_cfg_i.temperature_event_enable;
        flag_set[F_ANY_RDY] = (sample_i.p_done || sample_i.t_done)
                              && event_cfg_i.ready_event_enable;
        flag_set[F_ANY_OW]  = (p_ow_ev || t_ow_ev)
                              && event_cfg_i.ready_event_enable;
    end

    // clears fire only when the byte has left, never on a pointer load
    always_comb begin
        clr_p = 1'b0;
        clr_t = 1'b0;
        if (byte_sent_i) begin
            if (fifo_on) begin
                clr_p = (ptr_q == ssf_pkg::ADDR_FIFO_DATA_A) || (ptr_q == ssf_pkg::ADDR_FIFO_DATA);
                clr_t = clr_p;
            end else begin
                clr_p = (ptr_q == ssf_pkg::ADDR_P_MSB);
                clr_t = (ptr_q == ssf_pkg::ADDR_T_MSB);
            end
        end
        flag_clr = '0;
        flag_clr[F_P_RDY]   = clr_p;
        flag_clr[F_P_OW]    = clr_p;
        flag_clr[F_T_RDY]   = clr_t;
        flag_clr[F_T_OW]    = clr_t;
        flag_clr[F_ANY_RDY] = clr_p || clr_t;
        flag_clr[F_ANY_OW]  = clr_p || clr_t;
    end

    genvar gi;
    generate
        for (gi = 0; gi < ssf_pkg::NUM_FLAGS; gi++) begin : g_flag
            ssf_flag_cell u_cell (
                .core_clk_i (core_clk_i),
                .resetn_i   (resetn_i),
                .set_i      (flag_set[gi]),
                .clr_i      (flag_clr[gi]),
                .flag_o     (flag_q[gi])
            );
        end
    endgenerate

    // pointer, sample data and read byte
    always_comb begin
        ptr_d   = ptr_q;
        p_val_d = sample_i.p_done ? sample_i.p_value : p_val_q;
        t_val_d = sample_i.t_done ? sample_i.t_value : t_val_q;
        if (ptr_load_i) begin
            ptr_d = ptr_addr_i;
        end else if (byte_sent_i) begin
            ptr_d = next_addr(ptr_q, fifo_on);
        end
        rd_data_d = read_byte(ptr_d, fifo_on, status_byte, p_val_d, t_val_d,
                              fifo_status_i, fifo_data_i);
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ptr_q      <= ssf_pkg::ADDR_STATUS_ALIAS;
            p_val_q    <= '0;
            t_val_q    <= '0;
            rd_data_q  <= ssf_pkg::RD_DATA_RST;
            stat_out_q <= ssf_pkg::SAMPLE_STAT_RST;
        end else begin
            ptr_q      <= ptr_d;
            p_val_q    <= p_val_d;
            t_val_q    <= t_val_d;
            rd_data_q  <= rd_data_d;
            stat_out_q <= status_byte;
        end
    end

    assign rd_data_o       = rd_data_q;
    assign ptr_o           = ptr_q;
    assign sample_status_o = stat_out_q;

    a_alias_sample: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (ptr_d == ssf_pkg::ADDR_STATUS_ALIAS && !fifo_on) |=> (rd_data_o == $past(status_byte)))
        else $error("alias does not show sample status");
    a_alias_fifo: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (ptr_d == ssf_pkg::ADDR_STATUS_ALIAS && fifo_on) |=> (rd_data_o == $past(fifo_status_i)))
        else $error("alias does not show fifo status");
    a_burst_wrap: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (!ptr_load_i && byte_sent_i && ptr_q == ssf_pkg::ADDR_WRAP_LAST)
        |=> (ptr_o == ssf_pkg::ADDR_STATUS_ALIAS))
        else $error("pointer did not wrap to status");
    a_p_ready_set: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (sample_i.p_done && event_cfg_i.pressure_event_enable) |=> ##1 sample_status_o[2])
        else $error("pressure ready not set");
    a_p_ready_gate: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (!$past(flag_q[F_P_RDY]) && !$past(event_cfg_i.pressure_event_enable)) |-> !flag_q[F_P_RDY])
        else $error("pressure ready set while disabled");
    a_t_ow_set: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (sample_i.t_done && flag_q[F_T_RDY] && event_cfg_i.temperature_event_enable)
        |=> flag_q[F_T_OW])
        else $error("temperature overwrite not set");
    a_p_clear_read: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (clr_p && !sample_i.p_done) |=> !flag_q[F_P_RDY] && !flag_q[F_P_OW])
        else $error("pressure flags not cleared");
    a_clear_needs_send: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        ($past(flag_q[F_ANY_RDY]) && !flag_q[F_ANY_RDY]) |-> $past(byte_sent_i))
        else $error("flag cleared without a shipped byte");
    a_set_wins: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (flag_set[F_ANY_RDY] && flag_clr[F_ANY_RDY]) |=> flag_q[F_ANY_RDY])
        else $error("clear beat a simultaneous set");
    a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (sample_status_o[4] == 1'b0) && (sample_status_o[0] == 1'b0))
        else $error("reserved status bit set");
    a_any_ow_set: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (((sample_i.p_done && flag_q[F_P_RDY]) || (sample_i.t_done && flag_q[F_T_RDY]))
        && event_cfg_i.ready_event_enable) |=> flag_q[F_ANY_OW])
        else $error("combined overwrite not set");
    a_ow_fifo_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (byte_sent_i && fifo_on && ptr_q == ssf_pkg::ADDR_FIFO_DATA_A && !sample_i.p_done && !sample_i.t_done)
        |=> !flag_q[F_ANY_OW])
        else $error("combined overwrite kept after fifo read");
    a_p_ow_set: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (sample_i.p_done && flag_q[F_P_RDY] && event_cfg_i.pressure_event_enable) |=> flag_q[F_P_OW])
        else $error("pressure overwrite not set");
    a_p_ow_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (byte_sent_i && fifo_on && ptr_q == ssf_pkg::ADDR_FIFO_DATA && !sample_i.p_done)
        |=> !flag_q[F_P_OW])
        else $error("pressure overwrite kept after fifo read");
    a_t_ow_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (byte_sent_i && !fifo_on && ptr_q == ssf_pkg::ADDR_T_MSB && !sample_i.t_done)
        |=> !flag_q[F_T_OW])
        else $error("temperature overwrite kept after msb read");
    a_any_rdy_set: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        ((sample_i.p_done || sample_i.t_done) && event_cfg_i.ready_event_enable) |=> flag_q[F_ANY_RDY])
        else $error("combined ready not set");
    a_rdy_msb_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (byte_sent_i && !fifo_on && ptr_q == ssf_pkg::ADDR_T_MSB && !sample_i.p_done && !sample_i.t_done)
        |=> !flag_q[F_ANY_RDY])
        else $error("combined ready kept after msb read");
    a_t_ready_set: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (sample_i.t_done && event_cfg_i.temperature_event_enable) |=> flag_q[F_T_RDY])
        else $error("temperature ready not set");
    a_t_fifo_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (byte_sent_i && fifo_on && ptr_q == ssf_pkg::ADDR_FIFO_DATA_A && !sample_i.t_done)
        |=> !flag_q[F_T_RDY])
        else $error("temperature ready kept after fifo read");
    a_any_gate: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (!event_cfg_i.ready_event_enable && !flag_q[F_ANY_OW]) |=> !flag_q[F_ANY_OW])
        else $error("combined overwrite set while disabled");
    a_p_ow_gate: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (!event_cfg_i.pressure_event_enable && !flag_q[F_P_OW]) |=> !flag_q[F_P_OW])
        else $error("pressure overwrite set while disabled");
    a_t_ready_gate: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (!event_cfg_i.temperature_event_enable && !flag_q[F_T_RDY]) |=> !flag_q[F_T_RDY])
        else $error("temperature ready set while disabled");
    a_t_ow_gate: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (!event_cfg_i.temperature_event_enable && !flag_q[F_T_OW]) |=> !flag_q[F_T_OW])
        else $error("temperature overwrite set while disabled");
    a_t_live_data: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (ptr_d == ssf_pkg::ADDR_T_MSB && !fifo_on && !sample_i.t_done)
        |=> (rd_data_o == $past(t_val_q[11:4])))
        else $error("temperature msb not live sample");
    a_fifo_reserved: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (ptr_d == ssf_pkg::ADDR_P_CSB && fifo_on) |=> (rd_data_o == ssf_pkg::UNMAPPED_VALUE))
        else $error("reserved area not zero in fifo mode");
    a_fifo_pointer: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (!ptr_load_i && byte_sent_i && fifo_on && ptr_q == ssf_pkg::ADDR_FIFO_DATA_A)
        |=> (ptr_o == ssf_pkg::ADDR_FIFO_DATA_A))
        else $error("pointer left fifo data");
    a_load_no_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (ptr_load_i && !byte_sent_i && flag_q[F_P_RDY]) |=> flag_q[F_P_RDY])
        else $error("pointer load cleared a flag");
    a_pointer_load: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        ptr_load_i |=> (ptr_o == $past(ptr_addr_i)))
        else $error("pointer not loaded");
    a_direct_status: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (ptr_d == ssf_pkg::ADDR_SAMPLE_STAT) |=> (rd_data_o == $past(status_byte)))
        else $error("status register not shown at its own address");

    c_six_byte_burst: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        (byte_sent_i && ptr_q == ssf_pkg::ADDR_T_LSB && !fifo_on));
    c_p_overwrite: cover property (@(posedge core_clk_i) disable iff (!resetn_i) flag_set[F_P_OW]);
    c_fifo_clear: cover property (@(posedge core_clk_i) disable iff (!resetn_i) (clr_p && fifo_on));
    c_set_and_clear: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        (flag_set[F_P_RDY] && flag_clr[F_P_RDY]));
endmodule

// *** logic/ssf_pkg.sv ***
// shared constants and types for the sample status flag block
package ssf_pkg;
    localparam logic [7:0] ADDR_STATUS_ALIAS = 8'h00;
    localparam logic [7:0] ADDR_P_MSB        = 8'h01;
    localparam logic [7:0] ADDR_P_CSB        = 8'h02;
    localparam logic [7:0] ADDR_P_LSB        = 8'h03;
    localparam logic [7:0] ADDR_T_MSB        = 8'h04;
    localparam logic [7:0] ADDR_T_LSB        = 8'h05;
    localparam logic [7:0] ADDR_SAMPLE_STAT  = 8'h06;
    localparam logic [7:0] ADDR_FIFO_STAT    = 8'h0D;
    localparam logic [7:0] ADDR_FIFO_DATA    = 8'h0E;
    localparam logic [7:0] ADDR_WRAP_LAST    = 8'h05;
    localparam logic [7:0] ADDR_FIFO_DATA_A  = 8'h01;

    localparam int BIT_ANY_OW   = 7;
    localparam int BIT_P_OW     = 6;
    localparam int BIT_T_OW     = 5;
    localparam int BIT_ANY_RDY  = 3;
    localparam int BIT_P_RDY    = 2;
    localparam int BIT_T_RDY    = 1;
    localparam int NUM_FLAGS    = 6;

    localparam logic [7:0] SAMPLE_STAT_RST = 8'h00;
    localparam logic [7:0] RD_DATA_RST     = 8'h00;
    localparam logic [7:0] UNMAPPED_VALUE  = 8'h00;

    localparam logic [1:0] FMODE_OFF      = 2'h0;
    localparam logic [1:0] FMODE_CIRCULAR = 2'h1;
    localparam logic [1:0] FMODE_STOP     = 2'h2;

    // flag order inside the flag vector
    typedef enum logic [2:0] {
        F_ANY_OW, F_P_OW, F_T_OW, F_ANY_RDY, F_P_RDY, F_T_RDY
    } ssf_flag_idx_t;

    typedef struct packed {
        logic ready_event_enable;
        logic pressure_event_enable;
        logic temperature_event_enable;
    } ssf_evcfg_t;

    typedef struct packed {
        logic        p_done;
        logic        t_done;
        logic [19:0] p_value;
        logic [11:0] t_value;
    } ssf_sample_t;
endpackage

// *** logic/ssf_flag_cell.sv ***
// one sticky status flag where a set beats a clear in the same cycle
`timescale 1ns/1ps
module ssf_flag_cell (
    input  wire logic core_clk_i,  // system clock
    input  wire logic resetn_i,    // async reset, active low
    input  wire logic set_i,       // event pulse
    input  wire logic clr_i,       // clearing read pulse
    output logic      flag_o       // registered flag
);
    logic flag_d;
    logic flag_q;

    always_comb begin
        flag_d = flag_q;
        if (clr_i) begin
            flag_d = 1'b0;
        end
        if (set_i) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
endmodule

// *** tb/ssf_host_model.sv ***
// host controller model: register pointer loads and byte reads
`timescale 1ns/1ps
module ssf_host_model (
    input  wire logic       core_clk_i, // system clock
    input  wire logic [7:0] rd_data_i,  // byte at device pointer
    output logic            ptr_load_o, // pointer load pulse
    output logic [7:0]      ptr_addr_o, // pointer value
    output logic            byte_sent_o // byte shipped strobe
);
    logic [7:0] got [0:7];
    initial begin
        ptr_load_o = 1'b0;
        ptr_addr_o = 8'h00;
        byte_sent_o = 1'b0;
    end
    // address phase; an idle address shows its inverse so a stale value never matches
    task automatic set_ptr(input logic [7:0] a);
        ptr_load_o = 1'b1;
        ptr_addr_o = a;
        @(posedge core_clk_i);
        #1;
        ptr_load_o = 1'b0;
        ptr_addr_o = ~a;
        @(posedge core_clk_i);
        #1;
    endtask
    // auto-incrementing burst, each byte taken while it stands before the edge that ships it
    task automatic read_burst(input logic [7:0] a, input int n);
        set_ptr(a);
        byte_sent_o = 1'b1;
        for (int i = 0; i < n; i++) begin
            got[i] = rd_data_i;
            @(posedge core_clk_i);
            #1;
        end
        byte_sent_o = 1'b0;
    endtask
endmodule

// *** tb/sample_status_flags_tb.sv ***
// self-checking bench for the sample status flag block
`timescale 1ns/1ps
module sample_status_flags_tb;
    logic                 core_clk_i;
    logic                 resetn_i;
    logic [1:0]           fifo_mode_i;
    ssf_pkg::ssf_evcfg_t  event_cfg_i;
    ssf_pkg::ssf_sample_t sample_i;
    logic [7:0]           fifo_status_i;
    logic [7:0]           fifo_data_i;
    logic                 ptr_load;
    logic [7:0]           ptr_addr;
    logic                 byte_sent;
    logic [7:0]           rd_data;
    logic [7:0]           ptr;
    logic [7:0]           sstat;
    int                   bad_count = 0;
    int                   n_checks = 0;
    int                   cycles = 0;
    logic [7:0]           burst_exp [0:5] = '{8'hEE, 8'hAB, 8'hCD, 8'hE0, 8'h9A, 8'h70};
    logic [2:0]           cfgs [0:3] = '{3'h0, 3'h4, 3'h2, 3'h1};
    logic [7:0]           gexp [0:3] = '{8'h00, 8'h08, 8'h04, 8'h02};

    ssf_status_regs dut (
        .core_clk_i      (core_clk_i),
        .resetn_i        (resetn_i),
        .fifo_mode_i     (fifo_mode_i),
        .event_cfg_i     (event_cfg_i),
        .sample_i        (sample_i),
        .fifo_status_i   (fifo_status_i),
        .fifo_data_i     (fifo_data_i),
        .ptr_load_i      (ptr_load),
        .ptr_addr_i      (ptr_addr),
        .byte_sent_i     (byte_sent),
        .rd_data_o       (rd_data),
        .ptr_o           (ptr),
        .sample_status_o (sstat)
    );

    ssf_host_model host (
        .core_clk_i  (core_clk_i),
        .rd_data_i   (rd_data),
        .ptr_load_o  (ptr_load),
        .ptr_addr_o  (ptr_addr),
        .byte_sent_o (byte_sent)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        host.read_burst(a, 1);
        check(what, host.got[0], exp);
    endtask

    // one-cycle acquisition pulses, then time for flags to land
    task automatic pulse(input logic p, input logic t);
        sample_i.p_done = p;
        sample_i.t_done = t;
        @(posedge core_clk_i);
        #1;
        sample_i.p_done = 1'b0;
        sample_i.t_done = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask

    initial begin
        resetn_i = 1'b0;
        fifo_mode_i = ssf_pkg::FMODE_OFF;
        event_cfg_i = 3'h7;
        sample_i = '{p_done: 1'b0, t_done: 1'b0, p_value: 20'hABCDE, t_value: 12'h9A7};
        fifo_status_i = 8'hA5;
        fifo_data_i = 8'h3C;
        repeat (5) @(posedge core_clk_i);
        #1;
        check("status in reset", sstat, 8'h00);
        resetn_i = 1'b1;
        rd(ssf_pkg::ADDR_STATUS_ALIAS, 8'h00, "alias after reset");
        rd(ssf_pkg::ADDR_SAMPLE_STAT, 8'h00, "status after reset");
        $display("test reset done");
        pulse(1'b1, 1'b0);
        check("pressure ready", sstat, 8'h0C);
        pulse(1'b0, 1'b1);
        check("temperature ready", sstat, 8'h0E);
        pulse(1'b1, 1'b0);
        check("pressure overwrite", sstat, 8'hCE);
        pulse(1'b0, 1'b1);
        check("temperature overwrite", sstat, 8'hEE);
        host.read_burst(ssf_pkg::ADDR_STATUS_ALIAS, 6);
        for (int i = 0; i < 6; i++) check("burst byte", host.got[i], burst_exp[i]);
        check("pointer wrap", ptr, 8'h00);
        rd(ssf_pkg::ADDR_SAMPLE_STAT, 8'h00, "cleared by burst");
        pulse(1'b0, 1'b1);
        rd(ssf_pkg::ADDR_T_MSB, 8'h9A, "temperature msb");
        rd(ssf_pkg::ADDR_SAMPLE_STAT, 8'h00, "cleared by t msb");
        $display("test set and clear done");
        for (int i = 0; i < 4; i++) begin
            event_cfg_i = cfgs[i];
            pulse(1'b1, 1'b1);
            rd(ssf_pkg::ADDR_SAMPLE_STAT, gexp[i], "gated status");
            host.read_burst(ssf_pkg::ADDR_STATUS_ALIAS, 6);
        end
        event_cfg_i = 3'h7;
        $display("test enables done");
        for (int i = 1; i < 4; i++) begin
            fifo_mode_i = i[1:0];
            pulse(1'b1, 1'b0);
            rd(ssf_pkg::ADDR_STATUS_ALIAS, 8'hA5, "fifo alias");
            rd(ssf_pkg::ADDR_P_CSB, 8'h00, "fifo reserved");
            rd(ssf_pkg::ADDR_SAMPLE_STAT, 8'h0C, "flags before fifo read");
            rd((i == 2) ? ssf_pkg::ADDR_FIFO_DATA : ssf_pkg::ADDR_FIFO_DATA_A, 8'h3C, "fifo data");
            rd(ssf_pkg::ADDR_SAMPLE_STAT, 8'h00, "cleared by fifo read");
        end
        fifo_mode_i = ssf_pkg::FMODE_OFF;
        $display("test fifo done");
        pulse(1'b1, 1'b0);
        host.set_ptr(ssf_pkg::ADDR_P_MSB);
        rd(ssf_pkg::ADDR_SAMPLE_STAT, 8'h0C, "load only");
        rd(ssf_pkg::ADDR_P_MSB, 8'hAB, "pressure msb");
        fork
            host.read_burst(ssf_pkg::ADDR_P_MSB, 1);
            begin
                repeat (2) @(posedge core_clk_i);
                #1;
                sample_i.p_done = 1'b1;
                @(posedge core_clk_i);
                #1;
                sample_i.p_done = 1'b0;
            end
        join
        rd(ssf_pkg::ADDR_SAMPLE_STAT, 8'h0C, "set beats clear");
        $display("test priority done");
        final_report();
    end
endmodule
